// ===== shared/cfd_pkg.sv
package cfd_pkg;

    localparam logic [7:0] FLAGS_ADDR      = 8'hd5;
    localparam int         FAST_IRQ_POS    = 1;
    localparam int         BANK_POS        = 0;
    localparam logic       FAST_IRQ_RESET  = 1'b0;
    localparam logic       BANK_RESET      = 1'b0;
    localparam logic [7:0] OP_SEL_BANK0    = 8'h4f;
    localparam logic [7:0] OP_SEL_BANK1    = 8'h5f;
    localparam logic [7:0] OP_INT_RETURN   = 8'hbf;

    typedef enum logic [3:0] {
        MODE_WREG,
        MODE_WREG_BIT,
        MODE_WPAIR,
        MODE_REG,
        MODE_REG_PAIR,
        MODE_IND_ADDR,
        MODE_INDEXED,
        MODE_IDX_SHORT,
        MODE_IDX_LONG,
        MODE_DIRECT,
        MODE_RELATIVE,
        MODE_IMM,
        MODE_IMM_LONG
    } cfd_mode_t;

    typedef struct packed {
        cfd_mode_t   mode;
        logic [7:0]  byte0;
        logic [7:0]  byte1;
        logic [15:0] base;
        logic [15:0] next_pc;
    } cfd_opnd_req_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  reg_addr;
        logic [3:0]  wreg_index;
        logic [2:0]  bit_pos;
        logic [15:0] data;
        logic        is_wreg;
    } cfd_opnd_res_t;

endpackage

// ===== logic/cfd_core.sv
`timescale 1ns/10ps

// Operation
// RULE1: Set fast-irq bit on fast interrupt entry; clear it during interrupt return.
// RULE2: While fast-irq bit set, block all interrupt requests.
// RULE3: Interrupt return with fast-irq bit set performs fast return sequence.
// RULE4: Select-bank-zero instruction clears bank bit to 0.
// RULE5: Select-bank-one instruction sets bank bit to 1.
// RULE6: Working register index is 4 bits, direct or indirect.
// RULE7: Bit operand extracts 3-bit bit position 0 to 7.
// RULE8: Working pair index uses only even indices 0 to 14.
// RULE9: Full register operand carries 8-bit address 0 to 255.
// RULE10: Register pair as full address accepts even addresses 0 to 254.
// RULE11: Indirect call address is 8-bit even, pointing at 16-bit target.
// RULE12: Register-indexed address is 8-bit base plus working register contents.
// RULE13: Short-offset index adds signed 8-bit displacement to pair address.
// RULE14: Long-offset index adds 16-bit displacement to pair address.
// RULE15: Direct mode carries full 16-bit target address.
// RULE16: Relative target is next instruction address plus signed 8-bit offset.
// RULE17: Short immediate supplies 8-bit literal byte.
// RULE18: Long immediate supplies 16-bit literal word.
// RULE19: Both bits reset to 0; fast-irq bit read-only, bank bit writable.
// RULE20: Odd pair addresses are undefined and are not corrected.
module cfd_core (
    input  wire logic                   i_clock,
    input  wire logic                   i_rst_n,
    input  wire logic                   i_op_valid,
    input  wire logic [7:0]             i_opcode,
    input  wire logic                   i_fast_irq_enter,
    input  wire logic                   i_irq_request,
    input  wire logic                   i_reg_wr,
    input  wire logic [7:0]             i_reg_addr,
    input  wire logic [7:0]             i_reg_wdata,
    input  wire cfd_pkg::cfd_opnd_req_t i_opnd,
    output logic                        o_fast_irq_active_bit,
    output logic                        o_bank_bit,
    output logic [1:0]                  o_flags_low,
    output logic                        o_irq_accept,
    output logic                        o_fast_return,
    output logic                        o_normal_return,
    output cfd_pkg::cfd_opnd_res_t      o_opnd
);

    logic                   fast_irq_ff;
    logic                   bank_ff;
    logic                   irq_accept_ff;
    logic                   fast_ret_ff;
    logic                   norm_ret_ff;
    logic [15:0]            addr_ff;
    logic [7:0]             reg_addr_ff;
    logic [3:0]             wreg_index_ff;
    logic [2:0]             bit_pos_ff;
    logic [15:0]            data_ff;
    logic                   is_wreg_ff;
    cfd_pkg::cfd_opnd_res_t nxt_opnd;

    // True when a valid opcode in this cycle equals the given code
    function automatic logic op_match(input logic       valid,
                                      input logic [7:0] opcode,
                                      input logic [7:0] code);
        op_match = valid && (opcode == code);
    endfunction

    function automatic logic [3:0] pair_even(input logic [3:0] idx);
        pair_even = {idx[3:1], 1'b0};                          // [RULE8]
    endfunction

    function automatic logic [15:0] sext8(input logic [7:0] v);
        sext8 = {{8{v[7]}}, v};
    endfunction

    function automatic logic [15:0] join_bytes(input logic [7:0] hi,
                                               input logic [7:0] lo);
        join_bytes = {hi, lo};
    endfunction

    wire is_bank0_op = op_match(i_op_valid, i_opcode, cfd_pkg::OP_SEL_BANK0);
    wire is_bank1_op = op_match(i_op_valid, i_opcode, cfd_pkg::OP_SEL_BANK1);
    wire is_int_ret  = op_match(i_op_valid, i_opcode, cfd_pkg::OP_INT_RETURN);
    wire flags_wr    = i_reg_wr && (i_reg_addr == cfd_pkg::FLAGS_ADDR);
    wire wr_bank_val = i_reg_wdata[cfd_pkg::BANK_POS];

    // Entry wins over a return in the same cycle
    wire nxt_fast_irq = i_fast_irq_enter ? 1'b1 :              // [RULE1]
                        (is_int_ret ? 1'b0 : fast_irq_ff);     // [RULE1]
    // Bank instructions win over a register write in the same cycle
    wire nxt_bank     = is_bank0_op ? 1'b0 :                   // [RULE4]
                        is_bank1_op ? 1'b1 :                   // [RULE5]
                        flags_wr ? wr_bank_val : bank_ff;      // [RULE19]

    wire nxt_irq_accept = i_irq_request && !fast_irq_ff;       // [RULE2]
    wire nxt_fast_ret   = is_int_ret && fast_irq_ff;           // [RULE3]
    wire nxt_norm_ret   = is_int_ret && !fast_irq_ff;          // [RULE3]

    wire [3:0]  w_idx  = i_opnd.byte0[3:0];                    // [RULE6]
    wire [2:0]  w_bit  = i_opnd.byte0[6:4];                    // [RULE7]
    wire [3:0]  w_pair = pair_even(w_idx);                     // [RULE8]
    wire [15:0] word16 = join_bytes(i_opnd.byte1, i_opnd.byte0);
    wire [15:0] byte0w = join_bytes(8'h00, i_opnd.byte0);
    wire [15:0] idx_x  = join_bytes(8'h00, i_opnd.byte1) + i_opnd.base; // [RULE12]
    wire [15:0] idx_xs = i_opnd.base + sext8(i_opnd.byte1);    // [RULE13]
    wire [15:0] idx_xl = i_opnd.base + word16;                 // [RULE14]
    wire [15:0] rel    = i_opnd.next_pc + sext8(i_opnd.byte0); // [RULE16]

    // Every field is set in every mode so unused fields read as zero
    always_comb begin
        nxt_opnd = '0;
        unique case (i_opnd.mode)
            cfd_pkg::MODE_WREG: begin
                nxt_opnd.addr       = 16'h0000;
                nxt_opnd.reg_addr   = 8'h00;
                nxt_opnd.wreg_index = w_idx;                   // [RULE6]
                nxt_opnd.bit_pos    = 3'h0;
                nxt_opnd.data       = 16'h0000;
                nxt_opnd.is_wreg    = 1'b1;
            end

            cfd_pkg::MODE_WREG_BIT: begin
                nxt_opnd.addr       = 16'h0000;
                nxt_opnd.reg_addr   = 8'h00;
                nxt_opnd.wreg_index = w_idx;
                nxt_opnd.bit_pos    = w_bit;                   // [RULE7]
                nxt_opnd.data       = 16'h0000;
                nxt_opnd.is_wreg    = 1'b1;
            end

            cfd_pkg::MODE_WPAIR: begin
                nxt_opnd.addr       = 16'h0000;
                nxt_opnd.reg_addr   = 8'h00;
                nxt_opnd.wreg_index = w_pair;                  // [RULE8]
                nxt_opnd.bit_pos    = 3'h0;
                nxt_opnd.data       = 16'h0000;
                nxt_opnd.is_wreg    = 1'b1;
            end

            cfd_pkg::MODE_REG: begin
                nxt_opnd.addr       = 16'h0000;
                nxt_opnd.reg_addr   = i_opnd.byte0;            // [RULE9]
                nxt_opnd.wreg_index = 4'h0;
                nxt_opnd.bit_pos    = 3'h0;
                nxt_opnd.data       = 16'h0000;
                nxt_opnd.is_wreg    = 1'b0;
            end

            // Odd pair addresses pass through uncorrected
            cfd_pkg::MODE_REG_PAIR: begin
                nxt_opnd.addr       = 16'h0000;
                nxt_opnd.reg_addr   = i_opnd.byte0;            // [RULE10] [RULE20]
                nxt_opnd.wreg_index = 4'h0;
                nxt_opnd.bit_pos    = 3'h0;
                nxt_opnd.data       = 16'h0000;
                nxt_opnd.is_wreg    = 1'b0;
            end

            cfd_pkg::MODE_IND_ADDR: begin
                nxt_opnd.addr       = 16'h0000;
                nxt_opnd.reg_addr   = i_opnd.byte0;            // [RULE11]
                nxt_opnd.wreg_index = 4'h0;
                nxt_opnd.bit_pos    = 3'h0;
                nxt_opnd.data       = 16'h0000;
                nxt_opnd.is_wreg    = 1'b0;
            end

            cfd_pkg::MODE_INDEXED: begin
                nxt_opnd.addr       = idx_x;
                nxt_opnd.reg_addr   = idx_x[7:0];              // [RULE12]
                nxt_opnd.wreg_index = w_idx;
                nxt_opnd.bit_pos    = 3'h0;
                nxt_opnd.data       = 16'h0000;
                nxt_opnd.is_wreg    = 1'b0;
            end

            cfd_pkg::MODE_IDX_SHORT: begin
                nxt_opnd.addr       = idx_xs;                  // [RULE13]
                nxt_opnd.reg_addr   = 8'h00;
                nxt_opnd.wreg_index = w_pair;
                nxt_opnd.bit_pos    = 3'h0;
                nxt_opnd.data       = 16'h0000;
                nxt_opnd.is_wreg    = 1'b0;
            end

            cfd_pkg::MODE_IDX_LONG: begin
                nxt_opnd.addr       = idx_xl;                  // [RULE14]
                nxt_opnd.reg_addr   = 8'h00;
                nxt_opnd.wreg_index = w_pair;
                nxt_opnd.bit_pos    = 3'h0;
                nxt_opnd.data       = 16'h0000;
                nxt_opnd.is_wreg    = 1'b0;
            end

            cfd_pkg::MODE_DIRECT: begin
                nxt_opnd.addr       = word16;                  // [RULE15]
                nxt_opnd.reg_addr   = 8'h00;
                nxt_opnd.wreg_index = 4'h0;
                nxt_opnd.bit_pos    = 3'h0;
                nxt_opnd.data       = 16'h0000;
                nxt_opnd.is_wreg    = 1'b0;
            end

            cfd_pkg::MODE_RELATIVE: begin
                nxt_opnd.addr       = rel;                     // [RULE16]
                nxt_opnd.reg_addr   = 8'h00;
                nxt_opnd.wreg_index = 4'h0;
                nxt_opnd.bit_pos    = 3'h0;
                nxt_opnd.data       = 16'h0000;
                nxt_opnd.is_wreg    = 1'b0;
            end

            cfd_pkg::MODE_IMM: begin
                nxt_opnd.addr       = 16'h0000;
                nxt_opnd.reg_addr   = 8'h00;
                nxt_opnd.wreg_index = 4'h0;
                nxt_opnd.bit_pos    = 3'h0;
                nxt_opnd.data       = byte0w;                  // [RULE17]
                nxt_opnd.is_wreg    = 1'b0;
            end

            cfd_pkg::MODE_IMM_LONG: begin
                nxt_opnd.addr       = 16'h0000;
                nxt_opnd.reg_addr   = 8'h00;
                nxt_opnd.wreg_index = 4'h0;
                nxt_opnd.bit_pos    = 3'h0;
                nxt_opnd.data       = word16;                  // [RULE18]
                nxt_opnd.is_wreg    = 1'b0;
            end

            default: begin
                nxt_opnd = '0;
            end
        endcase
    end

    // One short register per status bit, pulse and operand field
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            fast_irq_ff <= cfd_pkg::FAST_IRQ_RESET;            // [RULE19]
        end else begin
            fast_irq_ff <= nxt_fast_irq;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            bank_ff <= cfd_pkg::BANK_RESET;                    // [RULE19]
        end else begin
            bank_ff <= nxt_bank;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            irq_accept_ff <= 1'b0;
        end else begin
            irq_accept_ff <= nxt_irq_accept;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            fast_ret_ff <= 1'b0;
        end else begin
            fast_ret_ff <= nxt_fast_ret;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            norm_ret_ff <= 1'b0;
        end else begin
            norm_ret_ff <= nxt_norm_ret;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            addr_ff <= 16'h0000;
        end else begin
            addr_ff <= nxt_opnd.addr;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            reg_addr_ff <= 8'h00;
        end else begin
            reg_addr_ff <= nxt_opnd.reg_addr;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            wreg_index_ff <= 4'h0;
        end else begin
            wreg_index_ff <= nxt_opnd.wreg_index;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            bit_pos_ff <= 3'h0;
        end else begin
            bit_pos_ff <= nxt_opnd.bit_pos;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            data_ff <= 16'h0000;
        end else begin
            data_ff <= nxt_opnd.data;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            is_wreg_ff <= 1'b0;
        end else begin
            is_wreg_ff <= nxt_opnd.is_wreg;
        end
    end

    assign o_fast_irq_active_bit = fast_irq_ff;
    assign o_bank_bit            = bank_ff;
    assign o_flags_low           = {fast_irq_ff, bank_ff};
    assign o_irq_accept          = irq_accept_ff;
    assign o_fast_return         = fast_ret_ff;
    assign o_normal_return       = norm_ret_ff;
    assign o_opnd.addr           = addr_ff;
    assign o_opnd.reg_addr       = reg_addr_ff;
    assign o_opnd.wreg_index     = wreg_index_ff;
    assign o_opnd.bit_pos        = bit_pos_ff;
    assign o_opnd.data           = data_ff;
    assign o_opnd.is_wreg        = is_wreg_ff;

endmodule

// ===== bench/cfd_assertions.sv
`timescale 1ns/10ps
module cfd_assertions (
    input wire logic       i_clock,
    input wire logic       i_rst_n,
    input wire logic       i_op_valid,
    input wire logic [7:0] i_opcode,
    input wire logic       i_fast_irq_enter,
    input wire logic       i_irq_request,
    input wire logic       i_reg_wr,
    input wire logic       o_fast_irq_active_bit,
    input wire logic       o_bank_bit,
    input wire logic       o_irq_accept,
    input wire logic       o_fast_return,
    input wire logic       o_normal_return
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    sequence s_int_ret; i_op_valid && i_opcode == cfd_pkg::OP_INT_RETURN; endsequence
    property p_bank1; i_op_valid && i_opcode == cfd_pkg::OP_SEL_BANK1 |=> o_bank_bit; endproperty
    a_bank1: assert property (p_bank1) else $error("bank one not set");
    property p_bank0; i_op_valid && i_opcode == cfd_pkg::OP_SEL_BANK0 |=> !o_bank_bit; endproperty
    a_bank0: assert property (p_bank0) else $error("bank zero not set");
    property p_fast_set; i_fast_irq_enter |=> o_fast_irq_active_bit; endproperty
    a_fast_set: assert property (p_fast_set) else $error("fast bit not set");
    property p_acc; i_irq_request && !o_fast_irq_active_bit |=> o_irq_accept; endproperty
    a_acc: assert property (p_acc) else $error("request not taken");
    property p_blk; o_fast_irq_active_bit |=> !o_irq_accept; endproperty
    a_blk: assert property (p_blk) else $error("request not blocked");
    property p_fret;
        s_int_ret ##0 (o_fast_irq_active_bit && !i_fast_irq_enter)
            |=> o_fast_return && !o_fast_irq_active_bit;
    endproperty
    a_fret: assert property (p_fret) else $error("fast return wrong");
    property p_nret;
        s_int_ret ##0 (!o_fast_irq_active_bit && !i_fast_irq_enter)
            |=> o_normal_return && !o_fast_return;
    endproperty
    a_nret: assert property (p_nret) else $error("normal return wrong");
    property p_ro; i_reg_wr && !i_fast_irq_enter && !i_op_valid
        |=> $stable(o_fast_irq_active_bit); endproperty
    a_ro: assert property (p_ro) else $error("fast bit written");
endmodule
bind cfd_core cfd_assertions i_cfd_assertions (.i_clock, .i_rst_n, .i_op_valid, .i_opcode,
    .i_fast_irq_enter, .i_irq_request, .i_reg_wr, .o_fast_irq_active_bit, .o_bank_bit,
    .o_irq_accept, .o_fast_return, .o_normal_return);

// ===== bench/cpu_flag_bits_operand_decode_test.sv
`timescale 1ns/10ps
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin err_count++; \
    $display("[ERR] %s exp %0h got %0h", n, e, a); end end
module cpu_flag_bits_operand_decode_test;
    logic                    clk = 0, rst_n = 0, vld = 0, ent = 0, irq = 0, wr = 0;
    logic [7:0]              opc = 0, wa = 0, wd = 0;
    logic                    fast, bank, acc, fret, nret;
    logic [1:0]              fl;
    cfd_pkg::cfd_opnd_req_t  req = '0;
    cfd_pkg::cfd_opnd_res_t  res;
    int                      err_count = 0, compares = 0;
    always #5 clk = ~clk;
    cfd_core i_cfd_core (.i_clock(clk), .i_rst_n(rst_n), .i_op_valid(vld), .i_opcode(opc),
        .i_fast_irq_enter(ent), .i_irq_request(irq), .i_reg_wr(wr), .i_reg_addr(wa),
        .i_reg_wdata(wd), .i_opnd(req), .o_fast_irq_active_bit(fast), .o_bank_bit(bank),
        .o_flags_low(fl), .o_irq_accept(acc), .o_fast_return(fret),
        .o_normal_return(nret), .o_opnd(res));
    task finish_test;
        $display("errors %0d compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task tick; @(posedge clk); #1; endtask
    task run(input logic v, input logic [7:0] o, input logic e, input logic q);
        vld = v; opc = o; ent = e; irq = q; tick; {vld, ent, irq} = 0;
    endtask
    task wreg(input logic [7:0] a, input logic [7:0] d); wr = 1; wa = a; wd = d; tick; wr = 0;
    endtask
    task op(input cfd_pkg::cfd_mode_t m, input logic [7:0] b0, input logic [7:0] b1,
            input logic [15:0] bs, input logic [15:0] pc);
        req = '{m, b0, b1, bs, pc}; tick;
    endtask
    initial begin #200000; err_count++; finish_test; end
    initial begin
        repeat (16) tick;
        rst_n = 1;
        `CHK("flags", 2'b00, fl)
        run(1, cfd_pkg::OP_SEL_BANK1, 0, 0); `CHK("bank1", 1'b1, bank)
        run(1, cfd_pkg::OP_SEL_BANK0, 0, 0); `CHK("bank0", 1'b0, bank)
        wreg(cfd_pkg::FLAGS_ADDR, 8'hff); `CHK("wr", 2'b01, fl)
        wreg(8'hd4, 8'h00); `CHK("wr_other", 1'b1, bank)
        run(0, 0, 0, 1); `CHK("acc", 1'b1, acc)
        run(0, 0, 1, 1); `CHK("fast", 1'b1, fast)
        wreg(cfd_pkg::FLAGS_ADDR, 8'h00); `CHK("fast_ro", 2'b10, fl)
        run(0, 0, 0, 1); `CHK("blk", 1'b0, acc)
        run(1, cfd_pkg::OP_INT_RETURN, 0, 0); `CHK("fret", 2'b10, {fret, fast})
        run(1, cfd_pkg::OP_INT_RETURN, 0, 0); `CHK("nret", 2'b01, {fret, nret})
        op(cfd_pkg::MODE_WREG, 8'h3f, 0, 0, 0); `CHK("wreg", 5'h1f, {res.is_wreg, res.wreg_index})
        op(cfd_pkg::MODE_REG, 8'hff, 0, 0, 0); `CHK("reg", 9'h0ff, {res.is_wreg, res.reg_addr})
        op(cfd_pkg::MODE_REG_PAIR, 8'hd5, 0, 0, 0); `CHK("rpair", 8'hd5, res.reg_addr)
        op(cfd_pkg::MODE_IND_ADDR, 8'hfe, 0, 0, 0); `CHK("ia", 8'hfe, res.reg_addr)
        op(cfd_pkg::MODE_DIRECT, 8'h34, 8'h12, 0, 0); `CHK("da", 16'h1234, res.addr)
        op(cfd_pkg::MODE_WREG_BIT, 8'h7a, 0, 0, 0); `CHK("bit", 3'h7, res.bit_pos)
        op(cfd_pkg::MODE_WPAIR, 8'h0f, 0, 0, 0); `CHK("pair", 4'he, res.wreg_index)
        op(cfd_pkg::MODE_INDEXED, 0, 8'hf0, 16'h0015, 0); `CHK("x", 16'h0105, res.addr)
        `CHK("x_reg", 8'h05, res.reg_addr)
        op(cfd_pkg::MODE_IDX_SHORT, 0, 8'h80, 16'h1000, 0); `CHK("xs", 16'h0f80, res.addr)
        op(cfd_pkg::MODE_IDX_LONG, 8'hff, 8'hff, 16'h0001, 0); `CHK("xl", 16'h0, res.addr)
        op(cfd_pkg::MODE_RELATIVE, 8'h7f, 0, 0, 16'h0100); `CHK("ra", 16'h017f, res.addr)
        op(cfd_pkg::MODE_IMM, 8'hff, 8'h12, 0, 0); `CHK("im", 16'h00ff, res.data)
        op(cfd_pkg::MODE_IMM_LONG, 8'hef, 8'hbe, 0, 0); `CHK("iml", 16'hbeef, res.data)
        finish_test;
    end
endmodule
